//--- verilog/csrb_defines.svh
`ifndef CSRB_DEFINES_SVH
`define CSRB_DEFINES_SVH
// What this block does
// - Unimplemented locations and unimplemented bits read back as zero.
// - Program counter upper bits have no direct path; only the holding latch or an increment carry reaches them.
// - Loading the program counter copies the latch into bits 12..8; latch writes alone do not.
// - Shared registers decode at the same offset in both banks, one physical register.
// - Reset pin and watchdog resets use the non-power-up reset values.
// - Non-power-up reset keeps unchanged bits; watchdog clears TO and sets PD, reset pin leaves them; unknown bits are free.
// - Optionally the power control register is absent and then reads zero.
// - Optionally converter control bit 5 is plain storage, else reads zero.

// Register indices; byte address is four times the index
`define CSRB_IDX_INDIRECT 8'h00
`define CSRB_IDX_TIMER 8'h01
`define CSRB_IDX_PCLOW 8'h02
`define CSRB_IDX_STATUS 8'h03
`define CSRB_IDX_POINTER 8'h04
`define CSRB_IDX_PORT_A_PINS 8'h05
`define CSRB_IDX_PORT_B_PINS 8'h06
`define CSRB_IDX_LATCH 8'h0a
`define CSRB_IDX_INTCTRL 8'h0b
`define CSRB_IDX_FLAGS 8'h0c
`define CSRB_IDX_RESULT 8'h1e
`define CSRB_IDX_CONVCTRL 8'h1f
`define CSRB_IDX_POWER 8'h8e
`define CSRB_BANK_SEL 8'h80

// Reset values
`define CSRB_STATUS_PU 8'h18
`define CSRB_POWER_POR 3'h5
`define CSRB_POWER_BOR 3'h6
`define CSRB_POWER_PER 3'h3

// Implemented bit masks
`define CSRB_STATUS_WMASK 8'he7
`define CSRB_PORT_A_PINS_MASK 8'h1f
`define CSRB_FLAGS_MASK 8'h40
`define CSRB_CONV_MASK 8'hfd
`define CSRB_CONV_BIT5_MASK 8'hdf

// Field positions
`define CSRB_ST_TO 4
`define CSRB_ST_PD 3
`define CSRB_CONV_GO 2
`define CSRB_CONV_BIT5 5
`define CSRB_FLAG_CONV 6
`define CSRB_IC_TMR 2
`define CSRB_IC_EXT 1
`define CSRB_IC_PORT_B_PINS 0
`endif

//--- verilog/csrb_pkg.sv
package csrb_pkg;
  typedef logic [7:0] csrb_byte_t;
  typedef logic [12:0] csrb_pc_t;
  typedef enum logic [1:0] {
    CSRB_RST_NONE = 2'b00,
    CSRB_RST_POWER = 2'b01,
    CSRB_RST_OTHER = 2'b10
  } csrb_rst_kind_t;
endpackage

//--- verilog/csrb_pc_if.sv
`timescale 1ns/100ps
interface csrb_pc_if;
  import csrb_pkg::*;
  logic load;
  logic inc;
  csrb_byte_t low;
  logic [4:0] latch;
  csrb_pc_t pc;
  modport unit (input load, input inc, input low, input latch, output pc);
  modport user (output load, output inc, output low, output latch, input pc);
endinterface

//--- verilog/csrb_pc_unit.sv
`timescale 1ns/100ps
module csrb_pc_unit
  import csrb_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Program counter port
  csrb_pc_if.unit pcif
);
  csrb_pc_t pc_q;
  csrb_pc_t pc_d;

  // Upper bits load only from the latch; an increment can also carry into them
  assign pc_d = pcif.load ? {pcif.latch, pcif.low} : (pcif.inc ? pc_q + 13'h0001 : pc_q);
  assign pcif.pc = pc_q;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pc_q <= 13'h0000;
    end else begin
      pc_q <= pc_d;
    end
  end

  a_pc_load_copy:
  assert property (@(posedge clk_sys_i) disable iff (rst_i)
    pcif.load |=> pc_q == {$past(pcif.latch), $past(pcif.low)})
    else $error("pc load did not copy latch");

  a_pc_upper_hold:
  assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !pcif.load && !pcif.inc |=> $stable(pc_q))
    else $error("pc changed without load");
endmodule

//--- verilog/csrb_top.sv
`timescale 1ns/100ps
`include "csrb_defines.svh"
module csrb_top
  import csrb_pkg::*;
#(
  parameter int PADDR_W = 12,
  parameter bit HAS_POWER_REG = 1'b1,
  parameter bit CONV_BIT5_STORE = 1'b1
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Reset causes, one-cycle pulses
  input wire logic brown_out_reset_i,
  input wire logic parity_error_reset_i,
  input wire logic external_reset_pin_i,
  input wire logic watchdog_reset_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [PADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Core and peripheral events
  input wire logic pc_inc_i,
  input wire logic timer_tick_i,
  input wire logic [7:0] port_a_pins_i,
  input wire logic [7:0] port_b_pins_i,
  input wire logic port_b_change_i,
  input wire logic ext_int_i,
  input wire logic conv_done_i,
  input wire logic [7:0] conv_result_i,
  // State outputs
  output logic [12:0] pc_o,
  output logic [7:0] status_o,
  output logic [7:0] port_a_latch_o,
  output logic [7:0] port_b_latch_o,
  output logic [7:0] int_ctrl_o,
  output logic [7:0] conv_ctrl_o
);
  if (PADDR_W < 11) begin : g_chk
    $error("PADDR_W must be at least 11");
  end

  csrb_pc_if pcif ();

  // Reset classification
  csrb_rst_kind_t rst_kind;
  logic pu_rst;
  logic np_rst;
  logic any_rst;
  assign pu_rst = reset_i | brown_out_reset_i | parity_error_reset_i;
  assign np_rst = ~pu_rst & (external_reset_pin_i | watchdog_reset_i);
  assign any_rst = pu_rst | np_rst;
  assign rst_kind = pu_rst ? CSRB_RST_POWER : (np_rst ? CSRB_RST_OTHER : CSRB_RST_NONE);

  // Address decode
  logic [7:0] idx;
  logic [7:0] lo;
  logic aligned;
  logic hit_ind;
  logic hit_pcl;
  logic hit_st;
  logic hit_ptr;
  logic hit_lath;
  logic hit_ic;
  logic hit_tmr;
  logic hit_pa;
  logic hit_pb;
  logic hit_flg;
  logic hit_res;
  logic hit_conv;
  logic hit_pwr;
  logic hit_any;
  assign idx = paddr_i[9:2];
  assign aligned = (paddr_i[1:0] == 2'h0) && (paddr_i[PADDR_W-1:10] == '0);
  assign lo = idx & ~`CSRB_BANK_SEL;
  // Shared registers ignore the bank bit
  assign hit_ind = aligned && (lo == `CSRB_IDX_INDIRECT);
  assign hit_pcl = aligned && (lo == `CSRB_IDX_PCLOW);
  assign hit_st = aligned && (lo == `CSRB_IDX_STATUS);
  assign hit_ptr = aligned && (lo == `CSRB_IDX_POINTER);
  assign hit_lath = aligned && (lo == `CSRB_IDX_LATCH);
  assign hit_ic = aligned && (lo == `CSRB_IDX_INTCTRL);
  assign hit_tmr = aligned && (idx == `CSRB_IDX_TIMER);
  assign hit_pa = aligned && (idx == `CSRB_IDX_PORT_A_PINS);
  assign hit_pb = aligned && (idx == `CSRB_IDX_PORT_B_PINS);
  assign hit_flg = aligned && (idx == `CSRB_IDX_FLAGS);
  assign hit_res = aligned && (idx == `CSRB_IDX_RESULT);
  assign hit_conv = aligned && (idx == `CSRB_IDX_CONVCTRL);
  assign hit_pwr = HAS_POWER_REG && aligned && (idx == `CSRB_IDX_POWER);
  assign hit_any = hit_ind | hit_pcl | hit_st | hit_ptr | hit_lath | hit_ic | hit_tmr
                 | hit_pa | hit_pb | hit_flg | hit_res | hit_conv | hit_pwr;

  // Storage
  logic [7:0] tmr_q;
  logic [7:0] st_q;
  logic [7:0] ptr_q;
  logic [7:0] pa_q;
  logic [7:0] pb_q;
  logic [4:0] lath_q;
  logic [7:0] ic_q;
  logic [7:0] flg_q;
  logic [7:0] res_q;
  logic [7:0] conv_q;
  logic [2:0] pwr_q;
  logic pready_q;
  logic [31:0] prdata_q;

  // Write strobe: only at the sampled access edge
  logic wr;
  logic setup_rd;
  logic [7:0] wd;
  assign wr = psel_i & penable_i & pwrite_i & pready_q;
  assign setup_rd = psel_i & ~penable_i & ~pwrite_i;
  assign wd = pwdata_i[7:0];

  // Next values
  logic tmr_wrap;
  logic [7:0] conv_mask;
  logic [7:0] st_d;
  logic [7:0] ic_d;
  logic [7:0] flg_d;
  logic [7:0] conv_d;
  logic [7:0] tmr_d;
  assign tmr_wrap = timer_tick_i & (tmr_q == 8'hff) & ~(wr & hit_tmr);
  assign tmr_d = (wr & hit_tmr) ? wd : (timer_tick_i ? tmr_q + 8'h01 : tmr_q);
  // Status flags TO and PD are read only
  assign st_d = (wr & hit_st) ? ((wd & `CSRB_STATUS_WMASK) | (st_q & ~`CSRB_STATUS_WMASK)) : st_q;
  // Hardware events win over a clearing write
  assign ic_d = ((wr & hit_ic) ? wd : ic_q)
              | {5'h00, tmr_wrap, ext_int_i, port_b_change_i};
  assign flg_d = ((wr & hit_flg) ? (wd & `CSRB_FLAGS_MASK) : flg_q)
               | (conv_done_i ? `CSRB_FLAGS_MASK : 8'h00);
  assign conv_mask = CONV_BIT5_STORE ? `CSRB_CONV_MASK : (`CSRB_CONV_MASK & `CSRB_CONV_BIT5_MASK);
  always_comb begin
    conv_d = (wr & hit_conv) ? (wd & conv_mask) : conv_q;
    // Conversion end drops GO unless software writes the same cycle
    if (conv_done_i && !(wr & hit_conv)) begin
      conv_d[`CSRB_CONV_GO] = 1'b0;
    end
  end

  // Program counter unit
  assign pcif.load = wr & hit_pcl;
  assign pcif.inc = pc_inc_i;
  assign pcif.low = wd;
  assign pcif.latch = lath_q;

  csrb_pc_unit u_pc (
    .clk_sys_i(clk_sys_i),
    .rst_i(any_rst),
    .pcif(pcif)
  );

  always_ff @(posedge clk_sys_i) begin
    if (pu_rst) begin
      tmr_q <= 8'h00;
    end else if (!np_rst) begin
      tmr_q <= tmr_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_kind == CSRB_RST_POWER) begin
      st_q <= `CSRB_STATUS_PU;
    end else if (rst_kind == CSRB_RST_OTHER) begin
      // Watchdog clears TO and sets PD; reset pin leaves both
      st_q[7:5] <= 3'h0;
      st_q[`CSRB_ST_TO] <= watchdog_reset_i ? 1'b0 : st_q[`CSRB_ST_TO];
      st_q[`CSRB_ST_PD] <= watchdog_reset_i ? 1'b1 : st_q[`CSRB_ST_PD];
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (pu_rst) begin
      ptr_q <= 8'h00;
      pa_q <= 8'h00;
      pb_q <= 8'h00;
      res_q <= 8'h00;
    end else if (!np_rst) begin
      ptr_q <= (wr & hit_ptr) ? wd : ptr_q;
      pa_q <= (wr & hit_pa) ? (wd & `CSRB_PORT_A_PINS_MASK) : pa_q;
      pb_q <= (wr & hit_pb) ? wd : pb_q;
      res_q <= conv_done_i ? conv_result_i : ((wr & hit_res) ? wd : res_q);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (any_rst) begin
      lath_q <= 5'h00;
      flg_q <= 8'h00;
      conv_q <= 8'h00;
    end else begin
      lath_q <= (wr & hit_lath) ? wd[4:0] : lath_q;
      flg_q <= flg_d;
      conv_q <= conv_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (pu_rst) begin
      ic_q <= 8'h00;
    end else if (np_rst) begin
      ic_q <= {7'h00, ic_q[`CSRB_IC_PORT_B_PINS]};
    end else begin
      ic_q <= ic_d;
    end
  end

  // Power cause bits, active low; software sets them back to one
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      pwr_q <= `CSRB_POWER_POR;
    end else if (brown_out_reset_i) begin
      pwr_q <= `CSRB_POWER_BOR;
    end else if (parity_error_reset_i) begin
      pwr_q <= `CSRB_POWER_PER;
    end else if (wr & hit_pwr & ~np_rst) begin
      pwr_q <= wd[2:0];
    end
  end

  // Read mux; anything not hit reads zero
  logic [7:0] rd_byte;
  assign rd_byte = ({8{hit_tmr}} & tmr_q)
                 | ({8{hit_pcl}} & pcif.pc[7:0])
                 | ({8{hit_st}} & st_q)
                 | ({8{hit_ptr}} & ptr_q)
                 | ({8{hit_pa}} & port_a_pins_i & `CSRB_PORT_A_PINS_MASK)
                 | ({8{hit_pb}} & port_b_pins_i)
                 | ({8{hit_lath}} & {3'h0, lath_q})
                 | ({8{hit_ic}} & ic_q)
                 | ({8{hit_flg}} & flg_q)
                 | ({8{hit_res}} & res_q)
                 | ({8{hit_conv}} & conv_q)
                 | ({8{hit_pwr}} & {5'h00, pwr_q});

  // Fixed one wait-free access phase; data sampled at setup
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= psel_i & ~penable_i;
      prdata_q <= setup_rd ? {24'h0, rd_byte} : prdata_q;
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = 1'b0;
  assign pc_o = pcif.pc;
  assign status_o = st_q;
  assign port_a_latch_o = pa_q;
  assign port_b_latch_o = pb_q;
  assign int_ctrl_o = ic_q;
  assign conv_ctrl_o = conv_q;

  a_unmapped_zero:
  assert property (@(posedge clk_sys_i) disable iff (reset_i)
    setup_rd && !hit_any |=> prdata_o == 32'h0 && pready_o)
    else $error("unmapped read not zero");

  a_shared_bank_latch:
  assert property (@(posedge clk_sys_i) disable iff (reset_i)
    setup_rd && aligned && (idx == (`CSRB_IDX_LATCH | `CSRB_BANK_SEL)) |=> prdata_o == {27'h0, $past(lath_q)})
    else $error("bank one latch alias broken");

  a_power_status_val:
  assert property (@(posedge clk_sys_i) disable iff (1'b0)
    pu_rst |=> st_q == `CSRB_STATUS_PU && pcif.pc == 13'h0000)
    else $error("power-up status value wrong");

  a_other_rst_keep:
  assert property (@(posedge clk_sys_i) disable iff (reset_i)
    np_rst |=> $stable(tmr_q) && $stable(ptr_q) && st_q[7:5] == 3'h0)
    else $error("unchanged bits lost on reset");

  a_wdog_timeout:
  assert property (@(posedge clk_sys_i) disable iff (reset_i)
    np_rst && watchdog_reset_i |=> !st_q[`CSRB_ST_TO] && st_q[`CSRB_ST_PD])
    else $error("watchdog cause bits wrong");

  a_power_absent:
  assert property (@(posedge clk_sys_i) disable iff (reset_i)
    setup_rd && !HAS_POWER_REG && aligned && idx == `CSRB_IDX_POWER |=> prdata_o == 32'h0)
    else $error("absent power register not zero");

  a_conv_bit5_zero:
  assert property (@(posedge clk_sys_i) disable iff (reset_i)
    CONV_BIT5_STORE || !conv_q[`CSRB_CONV_BIT5])
    else $error("converter bit 5 not zero");

  a_stray_write_none:
  assert property (@(posedge clk_sys_i) disable iff (any_rst)
    wr && !hit_any |=> $stable(ptr_q) && $stable(lath_q) && $stable(st_q) && $stable(pwr_q))
    else $error("stray write changed state");

  a_flag_set_wins:
  assert property (@(posedge clk_sys_i) disable iff (any_rst)
    conv_done_i |=> flg_q[`CSRB_FLAG_CONV] && !conv_q[`CSRB_CONV_GO] || $past(wr && hit_conv))
    else $error("conversion flag lost");

  a_latch_no_move:
  assert property (@(posedge clk_sys_i) disable iff (any_rst)
    wr && hit_lath && !pc_inc_i |=> $stable(pcif.pc))
    else $error("latch write moved pc");

  a_shared_status_alias:
  assert property (@(posedge clk_sys_i) disable iff (reset_i)
    setup_rd && aligned && (idx == (`CSRB_IDX_STATUS | `CSRB_BANK_SEL)) |=> prdata_o == {24'h0, $past(st_q)})
    else $error("bank one status alias broken");

  a_pointer_bank_alias:
  assert property (@(posedge clk_sys_i) disable iff (any_rst)
    wr && aligned && (idx == (`CSRB_IDX_POINTER | `CSRB_BANK_SEL)) |=> ptr_q == $past(wd))
    else $error("bank one pointer alias broken");

  a_port_a_pins_bits_zero:
  assert property (@(posedge clk_sys_i) disable iff (reset_i)
    setup_rd && hit_pa |=> prdata_o[7:5] == 3'h0)
    else $error("port a upper bits not zero");

  a_other_rst_clear:
  assert property (@(posedge clk_sys_i) disable iff (reset_i)
    np_rst |=> pcif.pc == 13'h0000 && lath_q == 5'h00 && ic_q[7:1] == 7'h00 && flg_q == 8'h00)
    else $error("other reset values wrong");

  a_other_rst_hold:
  assert property (@(posedge clk_sys_i) disable iff (reset_i)
    np_rst |=> $stable(pwr_q) && $stable(res_q) && $stable(pb_q))
    else $error("kept registers lost on reset");

  a_flag_bits_zero:
  assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (flg_q & ~`CSRB_FLAGS_MASK) == 8'h00 && !conv_q[1])
    else $error("unimplemented bit stored");
endmodule

//--- sim/csrb_core_model.sv
`timescale 1ns/100ps
module csrb_core_model (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Request side
  input wire logic start_i,
  input wire logic write_i,
  input wire logic [11:0] addr_i,
  input wire logic [31:0] wdata_i,
  output logic done_o,
  output logic [31:0] rdata_o,
  // APB master
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [11:0] paddr_o,
  output logic [31:0] pwdata_o,
  input wire logic pready_i,
  input wire logic [31:0] prdata_i
);
  // Released bus shows inverted values, so stale data never looks valid
  always_ff @(posedge clk_sys_i) begin
    done_o <= 1'b0;
    if (reset_i) begin
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      pwrite_o <= 1'b0;
      paddr_o <= 12'h000;
      pwdata_o <= 32'h0;
      rdata_o <= 32'h0;
    end else if (penable_o && pready_i) begin
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      done_o <= 1'b1;
      rdata_o <= prdata_i;
      paddr_o <= ~paddr_o;
      pwdata_o <= ~pwdata_o;
    end else if (psel_o) begin
      penable_o <= 1'b1;
    end else if (start_i) begin
      psel_o <= 1'b1;
      pwrite_o <= write_i;
      paddr_o <= addr_i;
      pwdata_o <= wdata_i;
    end
  end
endmodule

//--- sim/testbench.sv
`timescale 1ns/100ps
`include "csrb_defines.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module testbench;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic [3:0] rc = 4'h0;
  logic start = 1'b0;
  logic wr_r = 1'b0;
  logic [11:0] addr_r = 12'h000;
  logic [31:0] wdata_r = 32'h0;
  logic ext = 1'b0;
  logic cdone = 1'b0;
  logic [7:0] cres = 8'h00;
  logic done, psel, pen, pwr, prdy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [12:0] pc;
  logic [7:0] ictl;
  logic [7:0] st, pal, pbl, cvc;
  logic slverr;
  logic [31:0] prdata_v;
  logic [7:0] unimp [9] = '{8'h07, 8'h08, 8'h09, 8'h0d, 8'h1d, 8'h81, 8'h87, 8'h8c, 8'h8f};
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  initial forever #5 clk_sys_i = ~clk_sys_i;
  csrb_core_model csrb_core_model_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .start_i(start),
    .write_i(wr_r), .addr_i(addr_r), .wdata_i(wdata_r), .done_o(done), .rdata_o(rdata), .psel_o(psel),
    .penable_o(pen), .pwrite_o(pwr), .paddr_o(paddr), .pwdata_o(pwdata), .pready_i(prdy), .prdata_i(prdata));
  csrb_top csrb_top_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .brown_out_reset_i(rc[0]),
    .parity_error_reset_i(rc[1]), .external_reset_pin_i(rc[2]), .watchdog_reset_i(rc[3]), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(prdy),
    .pslverr_o(slverr), .pc_inc_i(1'b0), .timer_tick_i(1'b0), .port_a_pins_i(8'hea), .port_b_pins_i(8'hea),
    .port_b_change_i(1'b0), .ext_int_i(ext), .conv_done_i(cdone), .conv_result_i(cres), .pc_o(pc),
    .status_o(st), .port_a_latch_o(pal), .port_b_latch_o(pbl), .int_ctrl_o(ictl), .conv_ctrl_o(cvc));
  // Variant without power register and without converter bit 5, sharing the bus
  if (1'b1) begin : g_lite
    csrb_top #(.HAS_POWER_REG(1'b0), .CONV_BIT5_STORE(1'b0)) csrb_top_i (.clk_sys_i(clk_sys_i),
      .reset_i(reset_i), .brown_out_reset_i(rc[0]), .parity_error_reset_i(rc[1]),
      .external_reset_pin_i(rc[2]), .watchdog_reset_i(rc[3]), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_v), .pready_o(), .pslverr_o(),
      .pc_inc_i(1'b0), .timer_tick_i(1'b0), .port_a_pins_i(8'hea), .port_b_pins_i(8'hea),
      .port_b_change_i(1'b0), .ext_int_i(ext), .conv_done_i(cdone), .conv_result_i(cres), .pc_o(),
      .status_o(), .port_a_latch_o(), .port_b_latch_o(), .int_ctrl_o(), .conv_ctrl_o());
  end
  task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    start <= 1'b1;
    wr_r <= w;
    addr_r <= {2'b00, idx, 2'b00};
    wdata_r <= {24'h0, wd};
    @(posedge clk_sys_i);
    start <= 1'b0;
    do begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end while (done !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    rd = rdata[7:0];
  endtask
  task automatic wr8(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] d;
    acc(1'b1, idx, wd, d);
  endtask
  task automatic chk_rd(input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] d;
    acc(1'b0, idx, 8'h00, d);
    `CHK($sformatf("reg %h", idx), e, d)
  endtask
  task automatic cause(input logic [3:0] v);
    @(posedge clk_sys_i);
    rc <= v;
    @(posedge clk_sys_i);
    rc <= 4'h0;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Run is a few hundred bus cycles; ceiling leaves wide margin
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 8000) begin
      fails++;
      wrap_up;
    end
  end
  initial begin
    repeat (3) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    chk_rd(8'h03, `CSRB_STATUS_PU);
    chk_rd(8'h8e, {5'h00, `CSRB_POWER_POR});
    `CHK("power_absent", 32'h0, prdata_v)
    chk_rd(8'h0a, 8'h00);
    chk_rd(8'h00, 8'h00);
    foreach (unimp[i]) begin
      wr8(unimp[i], 8'hff);
      chk_rd(unimp[i], 8'h00);
    end
    chk_rd(8'h03, `CSRB_STATUS_PU);
    chk_rd(8'h05, 8'h0a);
    chk_rd(8'h06, 8'hea);
    wr8(8'h05, 8'hff);
    `CHK("port_a_latch", 8'h1f, pal)
    wr8(8'h06, 8'ha5);
    `CHK("port_b_latch", 8'ha5, pbl)
    wr8(8'h84, 8'h5c);
    chk_rd(8'h04, 8'h5c);
    wr8(8'h1f, 8'hff);
    chk_rd(8'h1f, 8'hfd);
    `CHK("conv_ctrl", 8'hfd, cvc)
    `CHK("bit5_absent", 32'hdd, prdata_v)
    wr8(8'h1f, 8'h00);
    wr8(8'h0a, 8'hf5);
    `CHK("pc", 13'h0000, pc)
    chk_rd(8'h8a, 8'h15);
    wr8(8'h82, 8'h34);
    `CHK("pc", 13'h1534, pc)
    chk_rd(8'h02, 8'h34);
    wr8(8'h83, 8'h27);
    chk_rd(8'h03, 8'h3f);
    chk_rd(8'h83, 8'h3f);
    wr8(8'h01, 8'h5a);
    wr8(8'h8b, 8'hff);
    chk_rd(8'h0b, 8'hff);
    cause(4'h8);
    chk_rd(8'h03, 8'h0f);
    `CHK("status", 8'h0f, st)
    chk_rd(8'h04, 8'h5c);
    `CHK("port_b_latch", 8'ha5, pbl)
    chk_rd(8'h0b, 8'h01);
    chk_rd(8'h01, 8'h5a);
    chk_rd(8'h8e, {5'h00, `CSRB_POWER_POR});
    chk_rd(8'h0a, 8'h00);
    `CHK("pc", 13'h0000, pc)
    wr8(8'h03, 8'h07);
    cause(4'h4);
    chk_rd(8'h03, 8'h0f);
    cause(4'h1);
    chk_rd(8'h03, `CSRB_STATUS_PU);
    chk_rd(8'h8e, {5'h00, `CSRB_POWER_BOR});
    cause(4'h2);
    chk_rd(8'h8e, {5'h00, `CSRB_POWER_PER});
    wr8(8'h1f, 8'h04);
    @(posedge clk_sys_i);
    cdone <= 1'b1;
    cres <= 8'h3c;
    ext <= 1'b1;
    @(posedge clk_sys_i);
    cdone <= 1'b0;
    ext <= 1'b0;
    chk_rd(8'h1e, 8'h3c);
    chk_rd(8'h0c, 8'h40);
    chk_rd(8'h1f, 8'h00);
    `CHK("int_ctrl", 8'h02, ictl)
    `CHK("pslverr", 1'b0, slverr)
    wrap_up;
  end
endmodule
